/* shared/ext_irq_pkg.sv */
package ext_irq_pkg;

  // Register byte addresses on APB (one aligned word each)
  localparam logic [7:0] STATUS_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] BREAK_CONTROL_ADDR  = 8'h04;

  // Field positions in irq_status_control
  localparam int MODE_POS  = 0;
  localparam int MASK_POS  = 1;
  localparam int ACK_POS   = 2;
  localparam int FLAG_POS  = 3;
  localparam int PIN_POS   = 4;

  // Field position in break_flag_control
  localparam int BREAK_CLEAR_POS = 7;

  // Reset values
  localparam logic       MODE_RESET = 1'b0;
  localparam logic       MASK_RESET = 1'b0;
  localparam logic       BREAK_CLEAR_RESET = 1'b0;
  localparam logic [2:0] SYNC_RESET = 3'b111;

  // Vector locations for this interrupt
  localparam logic [15:0] VECTOR_HIGH_ADDR = 16'hFFFA;
  localparam logic [15:0] VECTOR_LOW_ADDR  = 16'hFFFB;

endpackage : ext_irq_pkg

/* verification/cpu_vector_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_vector_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       irq_request,
  input  wire logic [3:0] delay,
  output logic            vector_fetch_ack
);
  logic [3:0] wait_reg;
  // Service delay then one vector fetch; a slow CPU leaves the request pending longer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg         <= 4'h0;
      vector_fetch_ack <= 1'b0;
    end else begin
      vector_fetch_ack <= irq_request && !vector_fetch_ack && (wait_reg == delay);
      wait_reg         <= (irq_request && wait_reg != delay) ? wait_reg + 4'h1 : 4'h0;
    end
  end
endmodule : cpu_vector_model
`default_nettype wire

/* verification/test_external_irq_latch.sv */
`timescale 1ns/1ps
`default_nettype none
module test_external_irq_latch;
  localparam logic [7:0] SC = ext_irq_pkg::STATUS_CONTROL_ADDR;
  localparam logic [7:0] BC = ext_irq_pkg::BREAK_CONTROL_ADDR;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pin_n = 1, brk = 0;
  logic [7:0]  paddr = 8'h00;
  logic [3:0]  dly = 4'h0;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, d;
  logic        pready, pslverr, ack, irq, pin_level;
  logic [15:0] vh, vl;
  int          bad_count = 0, checks = 0, cycles = 0, acks = 0, a0;
  integer      seed = 32'hcfed4190;
  external_irq_latch u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_interrupt_line_n(pin_n), .break_state(brk), .vector_fetch_ack(ack), .irq_request(irq),
    .vector_high_addr(vh), .vector_low_addr(vl), .pin_level(pin_level));
  cpu_vector_model u_cpu (.pclk(pclk), .presetn(presetn), .irq_request(irq), .delay(dly), .vector_fetch_ack(ack));
  always #4 pclk = ~pclk;
  // Count fetches and cut a hang short
  always @(posedge pclk) begin
    acks <= acks + int'(ack);
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] st(input logic mode, mask, flag, pin);
    return {27'h000_0000, pin, flag, 1'b0, mask, mode};
  endfunction : st
  task automatic check(input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rdchk
  // Pin settles through the synchroniser before anything is read
  task automatic pin(input logic v);
    @(posedge pclk);
    pin_n <= v;
    repeat (8) @(posedge pclk);
  endtask : pin
  task automatic tally_and_finish();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(SC, st(0, 0, 0, 1));
    rdchk(BC, 32'h0000_0000);
    rdchk(8'h08, 32'h0000_0000);
    check({vh, vl}, {ext_irq_pkg::VECTOR_HIGH_ADDR, ext_irq_pkg::VECTOR_LOW_ADDR});
    check({30'h0, pready, pslverr}, 32'h0000_0002);
    apb(1, SC, 32'h0000_0002);
    pin(0);
    check(irq, 0);
    check(pin_level, 0);
    rdchk(SC, st(0, 1, 1, 0));
    pin(1);
    brk <= 1'b1;
    apb(1, SC, 32'h0000_0006);
    rdchk(SC, st(0, 1, 1, 1));
    apb(1, BC, 32'h0000_0080);
    apb(1, SC, 32'h0000_0006);
    brk <= 1'b0;
    rdchk(SC, st(0, 1, 0, 1));
    pin(0);
    pin(1);
    rdchk(SC, st(0, 1, 1, 1));
    // Level mode: acknowledge while low, then the other order
    apb(1, SC, 32'h0000_0007);
    pin(0);
    apb(1, SC, 32'h0000_0007);
    rdchk(SC, st(1, 1, 1, 0));
    pin(1);
    rdchk(SC, st(1, 1, 0, 1));
    pin(0);
    pin(1);
    rdchk(SC, st(1, 1, 1, 1));
    apb(1, SC, 32'h0000_0007);
    rdchk(SC, st(1, 1, 0, 1));
    // Unmasked service with fast and slow vector fetch
    apb(1, SC, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      dly <= (i == 0) ? 4'h0 : 4'($random(seed));
      a0 = acks;
      pin(0);
      repeat (16) @(posedge pclk);
      rdchk(SC, st(0, 0, 0, 0));
      check(32'(acks - a0), 32'h0000_0001);
      pin(1);
    end
    // Random control writes with random pin levels
    repeat (20) begin
      d = $random(seed);
      dly <= d[11:8];
      apb(1, SC, d);
      pin(d[4]);
      apb(0, SC, 32'h0000_0000);
      check(rd & 32'h0000_0017, {27'h0, d[4], 2'b00, d[1:0]});
    end
    // Latch set, then a reset in mid-run
    pin(1);
    apb(1, SC, 32'h0000_0006);
    pin(0);
    pin(1);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rdchk(SC, st(0, 0, 0, 1));
    tally_and_finish();
  end
endmodule : test_external_irq_latch
`default_nettype wire

/* verilog/external_irq_latch.sv */
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - A low detected on the interrupt pin sets the request latch.
// - A vector fetch for this interrupt acknowledges and clears the latch.
// - Writing one to the acknowledge bit acknowledges and clears the latch.
// - Any reset clears the request latch.
// - Trigger select: 1 edges and low levels, 0 edges only; RW, reset clears.
// - Edge-only mode: latch holds until any acknowledge, then clears at once.
// - Level mode: latch clears only after acknowledge and pin high, any order.
// - Mask set withholds the request from the CPU priority logic.
// - Acknowledge does not stop later falling edges from setting the latch.
// - Unmasked service loads the program counter from the two vector locations.
// - Break clear enable 1 lets acknowledge clear the latch during break.
// - Break clear enable 0 makes acknowledge writes in break ineffective.
// - Acknowledge bit is write-only, reads zero, reset clears it.
// - Mask bit is RW: 1 disables, 0 enables, reset clears it.
// - Event flag reads 1 after an interrupt event, otherwise 0.
// - Current pin level is available to branch-on-pin-level instructions.
module external_irq_latch (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_interrupt_line_n,
  input  wire logic        break_state,
  input  wire logic        vector_fetch_ack,
  output logic             irq_request,
  output logic [15:0]      vector_high_addr,
  output logic [15:0]      vector_low_addr,
  output logic             pin_level
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: three stages, a change counts once stages 1 and 2 agree
  logic [2:0] sync_reg;
  logic       pin_stable_reg;
  logic       pin_stable_next;
  logic       fall_edge;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg       <= ext_irq_pkg::SYNC_RESET;
      pin_stable_reg <= 1'b1;
    end else begin
      sync_reg       <= {sync_reg[1:0], external_interrupt_line_n};
      pin_stable_reg <= pin_stable_next;
    end
  end

  // Stage 0 is read only by stage 1; filtered level feeds the edge detector
  assign pin_stable_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : pin_stable_reg;
  assign fall_edge       = pin_stable_reg & ~pin_stable_next;
  assign pin_level       = pin_stable_reg;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states, unmapped addresses read zero with no error
  logic wr_access;
  logic hit_status;
  logic hit_break;
  logic rd_setup;

  // Read data is captured in the setup cycle so it stands through the access phase
  assign rd_setup   = psel & ~penable & ~pwrite;
  assign wr_access  = psel & penable & pwrite;
  assign hit_status = (paddr == ext_irq_pkg::STATUS_CONTROL_ADDR);
  assign hit_break  = (paddr == ext_irq_pkg::BREAK_CONTROL_ADDR);
  assign pready     = 1'b1;
  assign pslverr    = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Control bits
  logic mode_reg;
  logic mask_reg;
  logic break_clear_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= ext_irq_pkg::MODE_RESET;
      mask_reg <= ext_irq_pkg::MASK_RESET;
      break_clear_reg <= ext_irq_pkg::BREAK_CLEAR_RESET;
    end else begin
      if (wr_access && hit_status) begin
        mode_reg <= pwdata[ext_irq_pkg::MODE_POS];
        mask_reg <= pwdata[ext_irq_pkg::MASK_POS];
      end
      if (wr_access && hit_break) begin
        break_clear_reg <= pwdata[ext_irq_pkg::BREAK_CLEAR_POS];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge and request latch
  logic sw_ack;
  logic ack_any;
  logic ack_seen_reg;
  logic ack_seen_next;
  logic latch_reg;
  logic latch_next;
  logic set_req;
  logic clear_ok;

  // Software acknowledge is blocked in break unless break clear is enabled
  assign sw_ack  = wr_access & hit_status & pwdata[ext_irq_pkg::ACK_POS]
                   & (~break_state | break_clear_reg);
  assign ack_any = sw_ack | vector_fetch_ack;

  // Level mode: remember an early acknowledge until the pin goes high
  assign ack_seen_next = mode_reg & latch_reg & (ack_any | ack_seen_reg) & ~pin_stable_next;

  // A new falling edge wins over an acknowledge in the same cycle
  assign set_req  = fall_edge | (mode_reg & ~pin_stable_next & ~(ack_any | ack_seen_reg));
  assign clear_ok = mode_reg ? ((ack_any | ack_seen_reg) & pin_stable_next) : ack_any;

  assign latch_next = set_req ? 1'b1 : (clear_ok ? 1'b0 : latch_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_reg    <= 1'b0;
      ack_seen_reg <= 1'b0;
    end else begin
      latch_reg    <= latch_next;
      ack_seen_reg <= ack_seen_next;
    end
  end

  // Masked requests never reach the CPU priority logic
  assign irq_request      = latch_reg & ~mask_reg;
  assign vector_high_addr = ext_irq_pkg::VECTOR_HIGH_ADDR;
  assign vector_low_addr  = ext_irq_pkg::VECTOR_LOW_ADDR;

  ////////////////////////////////////////////////////////////////////////////
  // Read data from flops; acknowledge bit always reads zero
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;

  assign rdata_next = hit_status ? {27'h000_0000, pin_stable_reg, latch_reg, 1'b0, mask_reg, mode_reg}
                    : hit_break ? {24'h00_0000, break_clear_reg, 7'h00}
                    : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_setup) begin
      rdata_reg <= rdata_next;
    end
  end

  assign prdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_EDGE_SETS: assert property (@(posedge pclk) disable iff (!presetn)
    fall_edge |=> latch_reg) else $error("falling edge did not set latch");
  AST_VF_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    (vector_fetch_ack && !mode_reg && !fall_edge) |=> !latch_reg) else $error("vector fetch did not clear");
  AST_SW_ACK: assert property (@(posedge pclk) disable iff (!presetn)
    (sw_ack && !mode_reg && !fall_edge) |=> !latch_reg) else $error("software ack did not clear");
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (latch_reg && !ack_any && !mode_reg) |=> latch_reg) else $error("latch dropped without ack");
  AST_LEVEL_PEND: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg && !pin_stable_next && latch_reg) |=> latch_reg) else $error("level request lost");
  AST_MASK: assert property (@(posedge pclk) disable iff (!presetn)
    mask_reg |-> !irq_request) else $error("masked request presented");
  AST_BREAK_PROT: assert property (@(posedge pclk) disable iff (!presetn)
    (break_state && !break_clear_reg && !vector_fetch_ack && !ack_seen_reg && latch_reg) |=> latch_reg)
    else $error("ack in break cleared latch");
  AST_ACK_READ0: assert property (@(posedge pclk) disable iff (!presetn)
    !prdata[ext_irq_pkg::ACK_POS]) else $error("ack bit read nonzero");
  AST_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_status) |=> (prdata[ext_irq_pkg::FLAG_POS] == $past(latch_reg)))
    else $error("flag read mismatch");

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser and edge detector checks

  // Each stage copies the one before it
  AST_SYNC_SHIFT: assert property (@(posedge pclk) disable iff (!presetn)
    sync_reg[2:1] == $past(sync_reg[1:0]))
    else $error("synchroniser did not shift");

  // Disagreeing stages must not move the filtered level
  AST_FILTER_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (sync_reg[1] != sync_reg[2]) |=> (pin_stable_reg == $past(pin_stable_reg)))
    else $error("filter moved on disagreement");

  // Agreeing stages are taken as the new level
  AST_FILTER_TAKE: assert property (@(posedge pclk) disable iff (!presetn)
    (sync_reg[1] == sync_reg[2]) |=> (pin_stable_reg == $past(sync_reg[2])))
    else $error("filter missed agreed level");

  // One falling edge gives one pulse, never two in a row
  AST_ONE_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    fall_edge |=> !fall_edge)
    else $error("edge pulse longer than one cycle");

  // An edge only follows two agreeing low samples
  AST_EDGE_AGREED: assert property (@(posedge pclk) disable iff (!presetn)
    fall_edge |-> ((sync_reg[1] == sync_reg[2]) && !sync_reg[2]))
    else $error("edge without agreed low");

  // Branch-on-level logic sees the filtered pin
  AST_PIN_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    pin_level == pin_stable_reg)
    else $error("pin level output wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Register bus checks

  // Zero wait states on every access
  AST_READY: assert property (@(posedge pclk) disable iff (!presetn)
    pready)
    else $error("ready low");

  // No access is ever refused
  AST_NO_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    !pslverr)
    else $error("slave error raised");

  // A status write loads the trigger select
  AST_MODE_WR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && hit_status) |=> (mode_reg == $past(pwdata[ext_irq_pkg::MODE_POS])))
    else $error("trigger select not written");

  // A status write loads the mask
  AST_MASK_WR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && hit_status) |=> (mask_reg == $past(pwdata[ext_irq_pkg::MASK_POS])))
    else $error("mask not written");

  // Trigger select moves only on a status write
  AST_MODE_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_access && hit_status) |=> $stable(mode_reg))
    else $error("trigger select changed by itself");

  // Mask moves only on a status write
  AST_MASK_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_access && hit_status) |=> $stable(mask_reg))
    else $error("mask changed by itself");

  // A break control write loads the break clear enable
  AST_BRK_WR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && hit_break) |=> (break_clear_reg == $past(pwdata[ext_irq_pkg::BREAK_CLEAR_POS])))
    else $error("break clear enable not written");

  // Break clear enable moves only on its own write
  AST_BRK_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_access && hit_break) |=> $stable(break_clear_reg))
    else $error("break clear enable changed by itself");

  // Read data is captured in the setup cycle
  AST_RD_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    rd_setup |=> (prdata == $past(rdata_next)))
    else $error("read data not captured");

  // Read data stands until the next read setup
  AST_RD_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !rd_setup |=> $stable(prdata))
    else $error("read data moved");

  // Trigger select reads back
  AST_RD_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_setup && hit_status) |=> (prdata[ext_irq_pkg::MODE_POS] == $past(mode_reg)))
    else $error("trigger select read wrong");

  // Mask reads back
  AST_RD_MASK: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_setup && hit_status) |=> (prdata[ext_irq_pkg::MASK_POS] == $past(mask_reg)))
    else $error("mask read wrong");

  // Pin level reads back
  AST_RD_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_setup && hit_status) |=> (prdata[ext_irq_pkg::PIN_POS] == $past(pin_stable_reg)))
    else $error("pin level read wrong");

  // Unused status bits read zero
  AST_RD_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_setup && hit_status) |=> (prdata[31:5] == 27'h000_0000))
    else $error("unused status bits nonzero");

  // Break control reads back with its other bits zero
  AST_RD_BRK: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_setup && hit_break) |=> (prdata == {24'h00_0000, $past(break_clear_reg), 7'h00}))
    else $error("break control read wrong");

  // Unmapped reads return zero
  AST_RD_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_setup && !hit_status && !hit_break) |=> (prdata == 32'h0000_0000))
    else $error("unmapped read nonzero");

  ////////////////////////////////////////////////////////////////////////////
  // Request latch checks

  // With break clear enabled, a software acknowledge in break still clears
  AST_SW_ACK_BREAK: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && hit_status && pwdata[ext_irq_pkg::ACK_POS] && break_state && break_clear_reg
     && !mode_reg && !fall_edge) |=> !latch_reg)
    else $error("enabled break ack did not clear");

  // Nothing sets the latch but an edge or a held low level
  AST_NO_SPONT_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (!latch_reg && !fall_edge && !(mode_reg && !pin_stable_next)) |=> !latch_reg)
    else $error("latch set without cause");

  // A held low level sets the latch when no acknowledge is pending
  AST_LEVEL_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg && !pin_stable_next && !ack_any && !ack_seen_reg) |=> latch_reg)
    else $error("low level did not set latch");

  // Acknowledge with the pin high clears in level mode
  AST_LEVEL_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg && ack_any && pin_stable_next) |=> !latch_reg)
    else $error("level ack did not clear");

  // An early acknowledge clears once the pin returns high
  AST_SEEN_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg && ack_seen_reg && pin_stable_next) |=> !latch_reg)
    else $error("remembered ack did not clear");

  // A remembered acknowledge only exists while the pin is low
  AST_SEEN_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    ack_seen_reg |-> !pin_stable_reg)
    else $error("remembered ack with pin high");

  // An unmasked latch is always presented
  AST_IRQ_UNMASKED: assert property (@(posedge pclk) disable iff (!presetn)
    (latch_reg && !mask_reg) |-> irq_request)
    else $error("unmasked request withheld");

  // No request without a latched event
  AST_IRQ_NEEDS_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    irq_request |-> latch_reg)
    else $error("request without latch");

  // The vector locations never move
  AST_VECTORS: assert property (@(posedge pclk) disable iff (!presetn)
    (vector_high_addr == ext_irq_pkg::VECTOR_HIGH_ADDR) && (vector_low_addr == ext_irq_pkg::VECTOR_LOW_ADDR))
    else $error("vector locations wrong");

  COV_EDGE: cover property (@(posedge pclk) disable iff (!presetn) fall_edge ##[1:20] sw_ack);
  COV_LEVEL: cover property (@(posedge pclk) disable iff (!presetn) mode_reg && ack_seen_reg);
  COV_BREAK: cover property (@(posedge pclk) disable iff (!presetn) break_state && break_clear_reg && sw_ack);
  COV_FETCH: cover property (@(posedge pclk) disable iff (!presetn) vector_fetch_ack && latch_reg);
  COV_LATE_ACK: cover property (@(posedge pclk) disable iff (!presetn) mode_reg && latch_reg && ack_any && pin_stable_next);

endmodule : external_irq_latch

`default_nettype wire
